// ### rtl/mdp_cfg.svh
// Register map, field positions, reset values and scaling shifts of the metering path.
`ifndef MDP_CFG_SVH
`define MDP_CFG_SVH

`define MDP_AW         5
// Control and trim registers.
`define MDP_REG_CFG0   5'h00
`define MDP_REG_CFG2   5'h01
`define MDP_REG_TRIM0  5'h02
`define MDP_REG_TRIM9  5'h0B
// Result registers, read only.
`define MDP_REG_WAVE_A 5'h10
`define MDP_REG_WAVE_B 5'h11
`define MDP_REG_WAVE_V 5'h12
`define MDP_REG_RMS_A  5'h13
`define MDP_REG_RMS_B  5'h14
`define MDP_REG_RMS_V  5'h15
`define MDP_REG_POWER  5'h16
`define MDP_REG_PEAK   5'h17
`define MDP_REG_PERIOD 5'h18
`define MDP_REG_STATUS 5'h19
// Trim slots, counted from the first trim register.
`define MDP_T_GAIN     4'h0
`define MDP_T_PGAIN    4'h3
`define MDP_T_PHASE    4'h4
`define MDP_T_RMSOS    4'h6
`define MDP_T_WATTOS   4'h9
// Configuration fields.
`define MDP_HPF_BYP    0
`define MDP_INT_EN     1
`define MDP_APF_BYP    2
`define MDP_CRN_W      3
`define MDP_CRN_RST    3'h6
// Fixed-point scaling.
`define MDP_GAIN_SHIFT 6'h1B
`define MDP_PWR_SHIFT  6'h1C
`define MDP_VSQ_SHIFT  6'h02
`define MDP_OS_SHIFT   6'h0F
`define MDP_HPF_BASE   4'h4

`endif

// ### rtl/mdp_pkg.sv
// Types shared by the metering path modules.
package mdp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FRONT, ST_GAIN, ST_PHASE, ST_SQUARE, ST_ROOT, ST_POWER, ST_PGAIN
  } mdp_state_t;

  typedef struct packed {
    mdp_state_t       st;
    logic [1:0]       idx;
    logic [2:0]       cfg0;
    logic [2:0]       crn;
    logic [9:0][31:0] trim;
    logic [2:0][31:0] raw;
    logic [2:0][31:0] work;
    logic [2:0][47:0] dc;
    logic [43:0]      integ;
    logic [31:0]      vprev;
    logic [1:0][31:0] ph_x1;
    logic [1:0][31:0] ph_y1;
    logic [2:0][63:0] msq;
    logic [63:0]      pflt;
    logic [31:0]      psel;
    logic [2:0][31:0] wave;
    logic [2:0][31:0] rms;
    logic [31:0]      power;
    logic [31:0]      peak;
    logic [15:0]      pcnt;
    logic [15:0]      period;
    logic             vneg;
    logic             sq_go;
    logic [63:0]      sq_arg;
    logic             res_stb;
    logic [31:0]      rdata;
  } mdp_core_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [63:0] arg;
    logic [63:0] op;
    logic [35:0] rem;
    logic [31:0] root;
  } mdp_root_t;

endpackage

// ### rtl/mdp_alu_if.sv
// Shared multiplier and square-root request lines between the core and its helpers.
`timescale 1ns/1ps
`default_nettype none
interface mdp_alu_if;
  logic signed [31:0] mul_a;
  logic signed [31:0] mul_b;
  logic        [5:0]  mul_shift;
  logic signed [63:0] mul_p;
  logic               sq_go;
  logic        [63:0] sq_arg;
  logic               sq_done;
  logic        [31:0] sq_root;
  modport core (output mul_a, mul_b, mul_shift, sq_go, sq_arg, input mul_p, sq_done, sq_root);
  modport mul  (input mul_a, mul_b, mul_shift, output mul_p);
  modport root (input sq_go, sq_arg, output sq_done, sq_root);
endinterface // mdp_alu_if
`default_nettype wire

// ### rtl/mdp_mul.sv
// Signed 32x32 multiplier with an arithmetic right shift of the product.
`timescale 1ns/1ps
`default_nettype none
module mdp_mul (
  // Operands and product.
  mdp_alu_if.mul alu
);
  logic signed [63:0] full;

  // Operands are at most 32 bits, so the full product never exceeds 64 bits.
  always_comb begin
    full      = alu.mul_a * alu.mul_b;
    alu.mul_p = full >>> alu.mul_shift;
  end
endmodule // mdp_mul
`default_nettype wire

// ### rtl/mdp_root.sv
// Iterative square root: 64-bit argument, 32-bit floor root, one bit per cycle.
`timescale 1ns/1ps
`default_nettype none
module mdp_root (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Request and answer.
  mdp_alu_if.root   alu
);
  import mdp_pkg::*;

  mdp_root_t   s;
  mdp_root_t   nx;
  logic [35:0] rem_sh;
  logic [35:0] trial;
  logic [65:0] sq_lo;
  logic [65:0] r1;

  always_comb begin
    nx      = s;
    rem_sh  = '0;
    trial   = '0;
    nx.done = 1'b0;
    if (!s.busy && alu.sq_go) begin
      nx.busy = 1'b1;
      nx.cnt  = '0;
      nx.arg  = alu.sq_arg;
      nx.op   = alu.sq_arg;
      nx.rem  = '0;
      nx.root = '0;
    end else if (s.busy) begin
      rem_sh = {s.rem[33:0], s.op[63:62]};
      trial  = {2'h0, s.root, 2'h1};
      nx.op  = {s.op[61:0], 2'h0};
      if (rem_sh >= trial) begin
        nx.rem  = rem_sh - trial;
        nx.root = {s.root[30:0], 1'b1};
      end else begin
        nx.rem  = rem_sh;
        nx.root = {s.root[30:0], 1'b0};
      end
      nx.cnt = s.cnt + 6'h01;
      if (s.cnt == 6'h1F) begin
        nx.busy = 1'b0;
        nx.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= nx;
    end
  end

  assign alu.sq_done = s.done;
  assign alu.sq_root = s.root;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  assign sq_lo = 66'(s.root) * 66'(s.root);
  assign r1    = 66'(s.root) + 66'h1;

  root_floor_a: assert property (
    s.done |-> (sq_lo <= 66'(s.arg)) && (r1 * r1 > 66'(s.arg)))
    else $error("square root is not the floor root");
  root_latency_a: assert property (
    (alu.sq_go && !s.busy) |-> ##33 s.done)
    else $error("square root answer not after 33 cycles");
  root_nonzero_c: cover property (s.done && s.root != 32'h0);
endmodule // mdp_root
`default_nettype wire

// ### rtl/mdp_core.sv
// Metering signal path: high-pass, integrator, gain, phase, rms and active power.
// Function
// - The integrator is only ever placed in channel B, never channel A.
// - The integrator falls 20 dB per decade with about -90 degrees of phase.
// - Channel B integrator is in the path only while its enable bit is set.
// - Each current channel has its own phase trim feeding a delay filter.
// - Voltage samples are delayed by exactly one processing sample.
// - Current delay filter coefficient is the signed phase trim times 2^-27.
// - Together the delays cover -15 degrees up to one voltage sample.
// - Voltage wave, rms and peak refresh every sample; period loads at each rising crossing.
// - Voltage gain trim uses the same format and equation as current gains.
// - Full-scale codes: wave 74565404, current rms 52725703, voltage rms 26362852.
// - Current rms full scale follows the input divided by that channel's gain stage.
// - Rms is the square root of the low-pass filtered square of each sample.
// - The rms filter suppresses mains harmonics at least 64 dB; bandwidth 1.6 kHz.
// - Current A, current B and voltage rms refresh once per sample.
// - Rms equals sqrt of raw rms squared plus signed offset trim times 2^15.
// - Active power is current times voltage, filtered unless the bypass bit is set.
// - Filtered power is scaled by the power gain trim, then offset trim added.
// - Active power refreshes every sample; full scale without gain is 10356306.
// - Power gain uses current gain format; power offset shares power result scaling.
// - Channel gain is one plus signed trim divided by 2^27.
// - The high-pass filter runs after reset and is bypassed by config bit 0.
// - A corner field in config word two halves the high-pass corner per code.
`timescale 1ns/1ps
`default_nettype none
`include "mdp_cfg.svh"
module mdp_core #(
  parameter int LPF_SHIFT = 14,
  parameter int INT_LEAK  = 8,
  parameter int INT_SHIFT = 3
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              reset,
  // Decimated samples with their shared strobe.
  input  wire logic              sample_strobe,
  input  wire logic [31:0]       current_a_sample,
  input  wire logic [31:0]       current_b_sample,
  input  wire logic [31:0]       voltage_sample,
  // Software register port.
  input  wire logic [`MDP_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  // One-cycle mark that all results were refreshed.
  output logic                   result_strobe
);
  import mdp_pkg::*;

  mdp_core_t          s;
  mdp_core_t          nx;
  logic [2:0][31:0]   hp;
  logic [31:0]        integ_in;
  logic [31:0]        gval;
  logic [31:0]        yval;
  logic signed [63:0] dlt;
  logic signed [64:0] rarg;
  logic [31:0]        absv;
  logic [31:0]        ph_diff;
  logic [31:0]        pk_abs;
  logic               trim_hit;
  logic [3:0]         trim_sel;

  if (LPF_SHIFT < 1 || LPF_SHIFT > 30 || INT_LEAK < 1 || INT_LEAK > 12 ||
      INT_SHIFT < 0 || INT_SHIFT > 8) begin : g_bad_param
    $error("mdp_core: filter shift parameter out of range");
  end

  // Sample-path and power results clip at the 32-bit two's complement limits.
  function automatic logic [31:0] sat32(input logic signed [64:0] v);
    logic [31:0] r;
    if (v > 65'sh0_7FFF_FFFF) r = 32'h7FFF_FFFF;
    else if (v < -65'sh0_8000_0000) r = 32'h8000_0000;
    else r = v[31:0];
    return r;
  endfunction

  // ==========================================================================
  // Shared multiplier and square root
  mdp_alu_if alu ();
  mdp_mul u_mul (.alu(alu));
  mdp_root u_root (.clock(clock), .reset(reset), .alu(alu));

  assign ph_diff = sat32(65'($signed(s.work[s.idx[0]])) - 65'($signed(s.ph_y1[s.idx[0]])));
  assign alu.mul_a = (s.st == ST_PHASE) ? ph_diff :
                     (s.st == ST_POWER) ? s.work[0] :
                     (s.st == ST_PGAIN) ? s.psel : s.work[s.idx];
  assign alu.mul_b = (s.st == ST_GAIN)  ? s.trim[`MDP_T_GAIN + 4'(s.idx)] :
                     (s.st == ST_PHASE) ? s.trim[`MDP_T_PHASE + 4'(s.idx)] :
                     (s.st == ST_POWER) ? s.work[2] :
                     (s.st == ST_PGAIN) ? s.trim[`MDP_T_PGAIN] : s.work[s.idx];
  // Voltage square is quartered so that voltage rms reads half of current rms.
  assign alu.mul_shift = (s.st == ST_POWER)  ? `MDP_PWR_SHIFT :
                         (s.st == ST_SQUARE) ? ((s.idx == 2'h2) ? `MDP_VSQ_SHIFT : 6'h00) :
                         `MDP_GAIN_SHIFT;
  assign alu.sq_go  = s.sq_go;
  assign alu.sq_arg = s.sq_arg;

  assign trim_hit = (reg_addr >= `MDP_REG_TRIM0) && (reg_addr <= `MDP_REG_TRIM9);
  assign trim_sel = 4'(reg_addr - `MDP_REG_TRIM0);

  // ==========================================================================
  // Next state
  always_comb begin
    nx         = s;
    hp         = '0;
    integ_in   = '0;
    gval       = '0;
    yval       = '0;
    dlt        = '0;
    rarg       = '0;
    absv       = '0;
    nx.res_stb = 1'b0;
    nx.sq_go   = 1'b0;
    nx.rdata   = '0;

    if (reg_write) begin
      if (reg_addr == `MDP_REG_CFG0) begin
        nx.cfg0 = reg_wdata[2:0];
      end else if (reg_addr == `MDP_REG_CFG2) begin
        nx.crn = reg_wdata[`MDP_CRN_W-1:0];
      end else if (trim_hit) begin
        nx.trim[trim_sel] = reg_wdata;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        `MDP_REG_CFG0:   nx.rdata = {29'h0, s.cfg0};
        `MDP_REG_CFG2:   nx.rdata = {29'h0, s.crn};
        `MDP_REG_WAVE_A: nx.rdata = s.wave[0];
        `MDP_REG_WAVE_B: nx.rdata = s.wave[1];
        `MDP_REG_WAVE_V: nx.rdata = s.wave[2];
        `MDP_REG_RMS_A:  nx.rdata = s.rms[0];
        `MDP_REG_RMS_B:  nx.rdata = s.rms[1];
        `MDP_REG_RMS_V:  nx.rdata = s.rms[2];
        `MDP_REG_POWER:  nx.rdata = s.power;
        `MDP_REG_PEAK:   nx.rdata = s.peak;
        `MDP_REG_PERIOD: nx.rdata = {16'h0, s.period};
        `MDP_REG_STATUS: nx.rdata = {31'h0, s.st != ST_IDLE};
        default:         nx.rdata = trim_hit ? s.trim[trim_sel] : 32'h0;
      endcase
      // Reading the peak restarts the hold; a sample landing now still counts.
      if (reg_addr == `MDP_REG_PEAK) nx.peak = '0;
    end

    unique case (s.st)
      ST_IDLE: begin
        // Strobes arriving while a sample is in flight are dropped.
        if (sample_strobe) begin
          nx.raw[0] = current_a_sample;
          nx.raw[1] = current_b_sample;
          nx.raw[2] = voltage_sample;
          nx.st     = ST_FRONT;
        end
      end
      ST_FRONT: begin
        for (int c = 0; c < 3; c++) begin
          hp[c] = sat32(65'($signed(s.raw[c])) - 65'($signed(s.dc[c][47:16])));
          if (s.cfg0[`MDP_HPF_BYP]) begin
            nx.work[c] = s.raw[c];
          end else begin
            // One-pole dc tracker; each code halves the corner.
            nx.dc[c]   = s.dc[c] + 48'($signed({hp[c], 16'h0}) >>>
                         (`MDP_HPF_BASE + 4'(s.crn)));
            nx.work[c] = hp[c];
          end
        end
        // Leaky integrator on channel B only; the leak keeps dc from ramping.
        integ_in = s.cfg0[`MDP_HPF_BYP] ? s.raw[1] : hp[1];
        if (s.cfg0[`MDP_INT_EN]) begin
          nx.integ   = s.integ + 44'($signed(integ_in)) -
                       44'($signed(s.integ) >>> INT_LEAK);
          nx.work[1] = sat32(65'($signed(nx.integ) >>> INT_SHIFT));
        end else begin
          nx.integ = '0;
        end
        nx.idx = '0;
        nx.st  = ST_GAIN;
      end
      ST_GAIN: begin
        // Same one-plus-trim gain equation for all three channels.
        gval = sat32(65'($signed(s.work[s.idx])) + 65'(alu.mul_p));
        if (s.idx == 2'h2) begin
          nx.vprev   = gval;
          nx.work[2] = s.vprev;
          nx.idx     = '0;
          nx.st      = ST_PHASE;
        end else begin
          nx.work[s.idx] = gval;
          nx.idx         = s.idx + 2'h1;
        end
      end
      ST_PHASE: begin
        // y = c*(x - y1) + x1: first-order allpass, c = trim / 2^27.
        yval = sat32(65'(alu.mul_p) + 65'($signed(s.ph_x1[s.idx[0]])));
        nx.ph_x1[s.idx[0]] = s.work[s.idx];
        nx.ph_y1[s.idx[0]] = yval;
        nx.work[s.idx]     = yval;
        if (s.idx == 2'h1) begin
          nx.idx = '0;
          nx.st  = ST_SQUARE;
        end else begin
          nx.idx = s.idx + 2'h1;
        end
      end
      ST_SQUARE: begin
        // Square scale follows the input, so any front-end gain is inherited.
        dlt = alu.mul_p - $signed(s.msq[s.idx]);
        nx.msq[s.idx] = s.msq[s.idx] + 64'(dlt >>> LPF_SHIFT);
        rarg = 65'($signed(nx.msq[s.idx])) +
               65'(64'($signed(s.trim[`MDP_T_RMSOS + 4'(s.idx)])) <<< `MDP_OS_SHIFT);
        nx.sq_arg = rarg[64] ? 64'h0 : rarg[63:0];
        nx.sq_go  = 1'b1;
        nx.st     = ST_ROOT;
      end
      ST_ROOT: begin
        if (alu.sq_done) begin
          nx.rms[s.idx] = alu.sq_root;
          if (s.idx == 2'h2) begin
            nx.idx = '0;
            nx.st  = ST_POWER;
          end else begin
            nx.idx = s.idx + 2'h1;
            nx.st  = ST_SQUARE;
          end
        end
      end
      ST_POWER: begin
        dlt     = alu.mul_p - $signed(s.pflt);
        nx.pflt = s.pflt + 64'(dlt >>> LPF_SHIFT);
        nx.psel = s.cfg0[`MDP_APF_BYP] ? sat32(65'(alu.mul_p)) :
                  sat32(65'($signed(nx.pflt)));
        nx.st   = ST_PGAIN;
      end
      ST_PGAIN: begin
        nx.power = sat32(65'($signed(s.psel)) + 65'(alu.mul_p) +
                   65'($signed(s.trim[`MDP_T_WATTOS])));
        nx.wave  = s.work;
        absv     = s.work[2][31] ? 32'(-$signed(s.work[2])) : s.work[2];
        nx.peak  = (absv > nx.peak) ? absv : nx.peak;
        nx.vneg  = s.work[2][31];
        if (s.vneg && !s.work[2][31]) begin
          nx.period = s.pcnt;
          nx.pcnt   = 16'h1;
        end else if (s.pcnt != 16'hFFFF) begin
          nx.pcnt = s.pcnt + 16'h1;
        end
        nx.res_stb = 1'b1;
        nx.st      = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s     <= '0;
      s.crn <= `MDP_CRN_RST;
    end else begin
      s <= nx;
    end
  end

  assign reg_rdata     = s.rdata;
  assign result_strobe = s.res_stb;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  assign pk_abs = s.wave[2][31] ? 32'(-$signed(s.wave[2])) : s.wave[2];

  chan_a_plain_a: assert property (
    (s.st == ST_FRONT && s.cfg0[`MDP_HPF_BYP]) |=> s.work[0] == $past(s.raw[0]))
    else $error("channel A changed with high-pass bypassed");
  integ_off_a: assert property (
    (s.st == ST_FRONT && s.cfg0[`MDP_HPF_BYP] && !s.cfg0[`MDP_INT_EN])
    |=> s.work[1] == $past(s.raw[1]))
    else $error("channel B altered with integrator off");
  volt_delay_a: assert property (
    (s.st == ST_GAIN && s.idx == 2'h2) |=> (s.work[2] == $past(s.vprev)) && s.st == ST_PHASE)
    else $error("voltage not delayed by one sample");
  unity_gain_a: assert property (
    (s.st == ST_GAIN && s.idx == 2'h0 && s.trim[`MDP_T_GAIN] == 32'h0)
    |=> s.work[0] == $past(s.work[0]))
    else $error("zero gain trim changed channel A");
  phase_zero_a: assert property (
    (s.st == ST_PHASE && s.idx == 2'h0 && s.trim[`MDP_T_PHASE] == 32'h0)
    |=> s.work[0] == $past(s.ph_x1[0]))
    else $error("zero phase trim is not a one-sample delay");
  sample_done_a: assert property (
    (s.st == ST_IDLE && sample_strobe) |-> ##[10:200] result_strobe)
    else $error("results not refreshed after a sample");
  power_raw_a: assert property (
    (s.st == ST_POWER && s.cfg0[`MDP_APF_BYP] && alu.mul_p == 64'($signed(alu.mul_p[31:0])))
    |=> s.psel == $past(alu.mul_p[31:0]))
    else $error("bypassed power is not the raw product");
  power_plain_a: assert property (
    (s.st == ST_PGAIN && s.trim[`MDP_T_PGAIN] == 32'h0 && s.trim[`MDP_T_WATTOS] == 32'h0)
    |=> s.power == $past(s.psel) && result_strobe)
    else $error("power altered with no gain or offset");
  peak_hold_a: assert property (
    result_strobe |-> s.peak >= pk_abs)
    else $error("voltage peak below the latest sample");
  // Wave and power results only move at a refresh, so software never reads them half-updated.
  result_hold_a: assert property (
    (s.st != ST_PGAIN)
    |=> $stable(s.wave) && $stable(s.power))
    else $error("results changed outside a refresh");
  // A rising crossing of the delayed voltage closes one line period.
  period_load_a: assert property (
    (s.st == ST_PGAIN && s.vneg && !s.work[2][31])
    |=> s.period == $past(s.pcnt))
    else $error("line period not loaded at a rising crossing");
  // Clearing the integrator while off avoids a step when it is switched back in.
  integ_clear_a: assert property (
    (s.st == ST_FRONT && !s.cfg0[`MDP_INT_EN])
    |=> s.integ == 44'h0)
    else $error("integrator state kept while disabled");
  hpf_hold_a: assert property (
    (s.st == ST_FRONT && s.cfg0[`MDP_HPF_BYP])
    |=> $stable(s.dc))
    else $error("dc tracker moved with high-pass bypassed");
  // A strobe that meets a busy engine must leave the captured samples alone.
  raw_hold_a: assert property (
    (s.st != ST_IDLE && sample_strobe)
    |=> $stable(s.raw))
    else $error("busy engine took a new sample");
  // The refresh mark is a single pulse, whatever follows it.
  strobe_pulse_a: assert property (
    result_strobe |=> !result_strobe)
    else $error("result strobe longer than one cycle");

  integ_used_c: cover property (s.st == ST_FRONT && s.cfg0[`MDP_INT_EN]);
  power_byp_c:  cover property (result_strobe && s.cfg0[`MDP_APF_BYP]);
  strobe_lost_c: cover property (s.st != ST_IDLE && sample_strobe);
  period_seen_c: cover property (s.st == ST_PGAIN && s.vneg && !s.work[2][31]);
endmodule // mdp_core
`default_nettype wire

// ### bench/mdp_adc_src.sv
// Upstream sample source: hands decimated samples to the path on one shared strobe.
`timescale 1ns/1ps
`default_nettype none
module mdp_adc_src (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Request and values from the bench.
  input  wire logic        go,
  input  wire logic [31:0] a_val,
  input  wire logic [31:0] b_val,
  input  wire logic [31:0] v_val,
  // Samples toward the path.
  output logic             sample_strobe,
  output logic [31:0]      current_a_sample,
  output logic [31:0]      current_b_sample,
  output logic [31:0]      voltage_sample
);
  logic [31:0] junk;
  // ==========
  // Sample lines
  // Outside the strobe cycle the lines churn, so a path that samples late reads garbage.
  always_ff @(posedge clock) begin
    junk             <= reset ? 32'h1357_9BDF : junk * 32'h0019_660D + 32'h3C6E_F35F;
    sample_strobe    <= go & ~reset;
    current_a_sample <= go ? a_val : junk;
    current_b_sample <= go ? b_val : ~junk;
    voltage_sample   <= go ? v_val : {junk[15:0], junk[31:16]};
  end
endmodule // mdp_adc_src
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench: drives the metering path and compares it with an integer model.
`timescale 1ns/1ps
`default_nettype none
`include "mdp_cfg.svh"
module testbench;
  // ==========
  // Signals and model state
  localparam logic [31:0] FI = 32'h0324_87C7;
  localparam logic [31:0] FV = 32'h0324_87C8;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        go = 1'b0;
  logic [31:0] a_val = 32'h0;
  logic [31:0] b_val = 32'h0;
  logic [31:0] v_val = 32'h0;
  logic        strobe;
  logic [31:0] cur_a;
  logic [31:0] cur_b;
  logic [31:0] volt;
  logic [4:0]  reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        result_strobe;
  logic [31:0] r;
  int          error_cnt = 0;
  int          checks_done = 0;
  longint      smp[3], e[3], g[3], tr[2], x1[2], y1[2], pk, ab;
  longint      vq[$] = '{0};

  always #5 clock = ~clock;

  mdp_adc_src src (.clock(clock), .reset(reset), .go(go), .a_val(a_val), .b_val(b_val),
    .v_val(v_val), .sample_strobe(strobe), .current_a_sample(cur_a),
    .current_b_sample(cur_b), .voltage_sample(volt));
  // A short filter shift lets rms and power settle in a few hundred samples.
  mdp_core #(.LPF_SHIFT(4), .INT_LEAK(8), .INT_SHIFT(3)) dut (.clock(clock), .reset(reset),
    .sample_strobe(strobe), .current_a_sample(cur_a), .current_b_sample(cur_b),
    .voltage_sample(volt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .result_strobe(result_strobe));

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic [31:0] seen, input longint exp);
    longint d;
    d = longint'(seen) - exp;
    chk(32'(d <= exp / 1024 + 2 && d >= -(exp / 1024 + 2)), 32'h1);
  endtask
  function automatic longint sat(input longint x);
    return x > 64'sh7FFF_FFFF ? 64'sh7FFF_FFFF : (x < -64'sh8000_0000 ? -64'sh8000_0000 : x);
  endfunction
  function automatic longint gn(input longint x, input longint t);
    return sat(x + ((x * t) >>> 27));
  endfunction
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic samp(input logic [31:0] a, input logic [31:0] b, input logic [31:0] v,
                      input bit poke);
    int n;
    logic [31:0] st;
    @(posedge clock);
    go <= 1'b1;
    a_val <= a;
    b_val <= b;
    v_val <= v;
    @(posedge clock);
    go <= 1'b0;
    n = 1;
    if (poke) begin
      // A second strobe while the engine is busy must be dropped.
      repeat (8) @(posedge clock);
      go <= 1'b1;
      a_val <= ~a;
      @(posedge clock);
      go <= 1'b0;
      rd(`MDP_REG_STATUS, st);
      chk(32'(st[0]), 32'h1);
      n = 12;
    end
    while (result_strobe !== 1'b1 && n < 250) begin
      @(posedge clock);
      #1 n++;
    end
    chk(32'(n >= 10 && n <= 200), 32'h1);
  endtask
  task automatic conclude();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========
  // Watchdog, about twice the expected run of some 36000 cycles
  initial begin
    #800_000;
    error_cnt++;
    conclude();
  end

  // ==========
  // Scenarios
  initial begin
    void'($urandom(93));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 12; a++) begin
      rd(5'(a), r);
      chk(r, a == 1 ? 32'h6 : 32'h0);
    end
    rd(5'h1F, r);
    chk(r, 32'h0);
    rd(`MDP_REG_CFG2, r);
    @(posedge clock) #1 chk(reg_rdata, 32'h0);
    for (int a = 2; a < 12; a++) begin
      r = $urandom();
      wr(5'(a), r);
      rd(5'(a), ab[31:0]);
      chk(ab[31:0], r);
      wr(5'(a), 32'h0);
    end
    wr(`MDP_REG_RMS_A, 32'h1234_5678);
    rd(`MDP_REG_RMS_A, r);
    chk(r, 32'h0);
    // High-pass on by default with the slowest-but-one corner, then the fastest corner.
    repeat (40) samp(32'h0100_0000, 32'h0100_0000, 32'h0100_0000, 1'b0);
    rd(`MDP_REG_WAVE_A, r);
    chk(32'(r > 32'h0080_0000), 32'h1);
    wr(`MDP_REG_CFG2, 32'h0);
    repeat (40) samp(32'h0100_0000, 32'h0100_0000, 32'h0100_0000, 1'b0);
    rd(`MDP_REG_WAVE_A, r);
    chk(32'($signed(r) < 32'sh0040_0000 && $signed(r) > -32'sh0040_0000), 32'h1);
    wr(`MDP_REG_CFG0, 32'h1);
    repeat (2) samp(32'h0, 32'h0, 32'h0, 1'b0);
    g[0] = 64'sh0800_0000;
    g[2] = -64'sh1000_0000;
    tr[0] = 64'sh0400_0000;
    tr[1] = -64'sh0400_0000;
    for (int k = 0; k < 3; k++) wr(5'(2 + k), 32'(g[k]));
    for (int k = 0; k < 2; k++) wr(5'(6 + k), 32'(tr[k]));
    rd(`MDP_REG_PEAK, r);
    for (int s = 0; s < 12; s++) begin
      for (int k = 0; k < 3; k++) smp[k] = longint'($urandom_range(32'h001F_FFFF)) - 64'sh10_0000;
      samp(32'(smp[0]), 32'(smp[1]), 32'(smp[2]), s == 5);
      for (int k = 0; k < 2; k++) begin
        e[k] = sat(((tr[k] * (gn(smp[k], g[k]) - y1[k])) >>> 27) + x1[k]);
        x1[k] = gn(smp[k], g[k]);
        y1[k] = e[k];
      end
      e[2] = vq.pop_front();
      vq.push_back(gn(smp[2], g[2]));
      ab = e[2] < 0 ? -e[2] : e[2];
      pk = ab > pk ? ab : pk;
      rd(`MDP_REG_WAVE_A, r);
      chk(r, 32'(e[0]));
      rd(`MDP_REG_WAVE_B, r);
      chk(r, 32'(e[1]));
      rd(`MDP_REG_WAVE_V, r);
      chk(r, 32'(e[2]));
    end
    rd(`MDP_REG_PEAK, r);
    chk(r, 32'(pk));
    rd(`MDP_REG_PEAK, r);
    chk(r, 32'h0);
    // With the doubling gain still on channel A this input must clip.
    wr(5'h06, 32'h0);
    repeat (2) samp(32'h7C00_0000, 32'h0, 32'h0, 1'b0);
    rd(`MDP_REG_WAVE_A, r);
    chk(r, 32'h7FFF_FFFF);
    wr(5'h02, 32'h0);
    wr(5'h04, 32'h0);
    wr(5'h07, 32'h0);
    wr(`MDP_REG_CFG0, 32'h7);
    repeat (4) samp(32'h0010_0000, 32'h0010_0000, 32'h0010_0000, 1'b0);
    rd(`MDP_REG_WAVE_A, r);
    chk(r, 32'h0010_0000);
    rd(`MDP_REG_WAVE_B, r);
    chk(32'(r !== 32'h0010_0000), 32'h1);
    wr(`MDP_REG_CFG0, 32'h5);
    repeat (3) samp(32'h0010_0000, 32'h0010_0000, 32'h0010_0000, 1'b0);
    rd(`MDP_REG_WAVE_B, r);
    chk(r, 32'h0010_0000);
    // Full-scale dc levels: rms equals the level, voltage rms half of it.
    // Enough samples for the clipped square left in channel A to die away.
    wr(`MDP_REG_CFG0, 32'h1);
    repeat (200) samp(FI, FI, FV, 1'b0);
    rd(`MDP_REG_RMS_A, r);
    near(r, longint'(FI));
    rd(`MDP_REG_RMS_B, r);
    near(r, longint'(FI));
    rd(`MDP_REG_RMS_V, r);
    near(r, 64'h0192_43E4);
    rd(`MDP_REG_POWER, r);
    near(r, 64'h009E_0652);
    wr(`MDP_REG_CFG0, 32'h5);
    wr(5'h05, 32'h0800_0000);
    wr(5'h0B, 32'h0000_1000);
    wr(5'h08, 32'h4000_0000);
    samp(FI, FI, FV, 1'b0);
    ab = (longint'(FI) * longint'(FV)) >>> 28;
    rd(`MDP_REG_POWER, r);
    chk(r, 32'(2 * ab + 64'h1000));
    rd(`MDP_REG_RMS_A, r);
    near(r, longint'($sqrt(real'(FI) * real'(FI) + 32768.0 * 1073741824.0)));
    conclude();
  end
endmodule // testbench
`default_nettype wire
